// >>> rtl/indirect_memory_mapper.sv
`timescale 1ns/1ps
module indirect_memory_mapper
    import imm_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic ARST_N,
    // Core request through the indirect data port.
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic [15:0] REQ_POINTER,
    input wire logic [7:0] REQ_WDATA,
    output logic REQ_BUSY,
    // Answer to the core.
    output logic RSP_VALID,
    output logic [7:0] RSP_RDATA,
    // Banked data memory port.
    output mem_req_s MEM,
    input wire logic [7:0] MEM_RDATA,
    // Program flash read port.
    output flash_req_s FLASH,
    input wire logic [13:0] FLASH_RDATA
);

    // Control state and the registered values that follow it.
    map_state_e state;
    map_state_e next_state;
    mem_req_s next_mem;
    flash_req_s next_flash;
    logic next_rsp_valid;
    logic [7:0] next_rsp_rdata;

    // Request take and pointer window flags.
    logic take;
    logic is_flash;
    logic is_linear;
    logic is_banked;
    logic is_mapped;

    // Linear and banked translations of the pointer.
    logic [11:0] lin_off;
    logic [11:0] lin_bank;
    logic [11:0] lin_byte;
    logic [6:0] lin_index;
    logic [4:0] bnk_bank;
    logic [6:0] bnk_index;
    logic [4:0] dec_bank;
    logic [6:0] dec_index;

    // The core may present a new request only while the mapper is idle.
    assign REQ_BUSY = (state != ST_IDLE);

    // A request is taken at the edge where it meets an idle mapper.
    assign take = REQ_VALID && (state == ST_IDLE);

    // Window classification of the presented pointer.
    always_comb begin
        is_flash = REQ_POINTER[FLASH_SEL_BIT];
        is_linear = !is_flash && (REQ_POINTER >= LINEAR_BASE)
            && (REQ_POINTER <= LINEAR_LAST);
        is_banked = (REQ_POINTER <= BANKED_LAST);
        // Everything else in the data half is unimplemented.
        is_mapped = is_linear || is_banked;
    end

    // Linear view: the offset is split into bank and byte by the general RAM bytes per bank.
    always_comb begin
        // The base has no low bits set, so the offset is the low bits.
        lin_off = REQ_POINTER[11:0] - LINEAR_BASE[11:0];
        lin_bank = lin_off / GENERAL_RAM_BYTES;
        lin_byte = lin_off % GENERAL_RAM_BYTES;
        // Bytes land after the register area; common RAM is never hit.
        lin_index = GENERAL_RAM_FIRST + lin_byte[6:0];
    end

    // Banked view: upper bits pick the bank, low seven bits the byte.
    always_comb begin
        bnk_bank = REQ_POINTER[11:7];
        bnk_index = REQ_POINTER[6:0];
        // Every bank's common slice folds onto one storage.
        if (REQ_POINTER[6:0] >= COMMON_FIRST) begin
            bnk_bank = COMMON_BANK;
        end
    end

    // Selection of the bank and byte handed to the data memory.
    always_comb begin
        // Unmapped pointers keep zero here; they raise no strobe anyway.
        dec_bank = 5'h00;
        dec_index = 7'h00;
        if (is_linear) begin
            dec_bank = lin_bank[4:0];
            dec_index = lin_index;
        end else if (is_banked) begin
            dec_bank = bnk_bank;
            dec_index = bnk_index;
        end
    end

    // Control state: idle, one data cycle, or two flash cycles.
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                // Flash pointers take the longer path with its extra cycle.
                if (take && is_flash) begin
                    next_state = ST_FLASH_A;
                end else if (take) begin
                    next_state = ST_DATA;
                end
            end
            ST_DATA: begin
                // Data accesses answer in the following cycle.
                next_state = ST_IDLE;
            end
            ST_FLASH_A: begin
                // The extra cycle that every flash access costs.
                next_state = ST_FLASH_B;
            end
            ST_FLASH_B: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // The state register alone.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Data memory strobe: one cycle, only for mapped data pointers.
    always_comb begin
        next_mem = '0;
        if (take && !is_flash) begin
            // Unmapped pointers raise no strobe and so read as zero.
            next_mem.en = is_mapped;
            next_mem.we = REQ_WRITE;
            next_mem.bank = dec_bank;
            next_mem.index = dec_index;
            next_mem.wdata = REQ_WDATA;
        end
    end

    // The data memory strobe register.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            MEM <= '0;
        end else begin
            MEM <= next_mem;
        end
    end

    // Flash strobe: raised on a taken read, held through the extra cycle.
    always_comb begin
        next_flash = '0;
        if (take && is_flash) begin
            // A write into the flash window raises no strobe at all.
            next_flash.en = !REQ_WRITE;
            next_flash.addr = REQ_POINTER[14:0];
        end else if (state == ST_FLASH_A) begin
            // Held unchanged for one more clock.
            next_flash = FLASH;
        end
    end

    // The flash strobe register.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            FLASH <= '0;
        end else begin
            FLASH <= next_flash;
        end
    end

    // Answer: one pulse after the last cycle of every access.
    always_comb begin
        next_rsp_valid = 1'b0;
        next_rsp_rdata = ZERO_BYTE;
        if (state == ST_DATA) begin
            next_rsp_valid = 1'b1;
            // Writes and unmapped reads answer with a zero byte.
            if (MEM.en && !MEM.we) begin
                next_rsp_rdata = MEM_RDATA;
            end
        end else if (state == ST_FLASH_B) begin
            next_rsp_valid = 1'b1;
            // Only the low byte of the program word reaches the core.
            if (FLASH.en) begin
                next_rsp_rdata = FLASH_RDATA[7:0];
            end
        end
    end

    // The answer registers.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RSP_VALID <= 1'b0;
            RSP_RDATA <= ZERO_BYTE;
        end else begin
            RSP_VALID <= next_rsp_valid;
            RSP_RDATA <= next_rsp_rdata;
        end
    end

endmodule

// >>> rtl/imm_pkg.sv
package imm_pkg;

    // Pointer map boundaries.
    localparam logic [15:0] BANKED_LAST = 16'h0fff;
    localparam logic [15:0] LINEAR_BASE = 16'h2000;
    localparam logic [15:0] LINEAR_LAST = 16'h29af;
    localparam int FLASH_SEL_BIT = 15;

    // Bank layout: general RAM follows the special-register area.
    localparam logic [11:0] GENERAL_RAM_BYTES = 12'h050;
    localparam logic [6:0] GENERAL_RAM_FIRST = 7'h20;
    localparam logic [6:0] COMMON_FIRST = 7'h70;
    localparam logic [4:0] COMMON_BANK = 5'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Strobe towards the banked data memory.
    typedef struct packed {
        logic en;
        logic we;
        logic [4:0] bank;
        logic [6:0] index;
        logic [7:0] wdata;
    } mem_req_s;

    // Strobe towards program flash, read only.
    typedef struct packed {
        logic en;
        logic [14:0] addr;
    } flash_req_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DATA = 2'b01,
        ST_FLASH_A = 2'b10,
        ST_FLASH_B = 2'b11
    } map_state_e;

endpackage

// >>> bench/imm_chk_sva.sv
`timescale 1ns/1ps
module imm_chk
    import imm_pkg::*;
(
    // Mapper ports under watch.
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic [15:0] REQ_POINTER,
    input wire logic REQ_BUSY,
    input wire mem_req_s MEM,
    input wire flash_req_s FLASH
);
    // Taken request, its kind and its linear offset.
    logic tk, fl, lin;
    logic [15:0] off;
    assign tk = REQ_VALID && !REQ_BUSY;
    assign fl = tk && REQ_POINTER[15];
    assign lin = tk && REQ_POINTER inside {[LINEAR_BASE:LINEAR_LAST]};
    assign off = REQ_POINTER - LINEAR_BASE;
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    // Busy span, strobes and placement of each taken request.
    data_busy_a: assert property (tk && !REQ_POINTER[15]
        |=> REQ_BUSY ##1 !REQ_BUSY) else $error("data busy span");
    flash_busy_a: assert property (fl
        |=> REQ_BUSY [*2] ##1 !REQ_BUSY) else $error("flash busy span");
    flash_addr_a: assert property (fl && !REQ_WRITE |=> FLASH.en
        && FLASH.addr == $past(REQ_POINTER[14:0])) else $error("flash addr");
    flash_no_write_a: assert property (fl && REQ_WRITE
        |=> !(FLASH.en || MEM.en) [*2]) else $error("flash written");
    lin_bank_a: assert property (lin |=> MEM.en
        && MEM.bank == 5'($past(off) / GENERAL_RAM_BYTES))
        else $error("linear bank");
    lin_index_a: assert property (lin |=> MEM.index ==
        7'($past(off) % GENERAL_RAM_BYTES) + GENERAL_RAM_FIRST)
        else $error("linear index");
    bank_index_a: assert property (tk && REQ_POINTER <= BANKED_LAST
        |=> MEM.index == $past(REQ_POINTER[6:0])) else $error("bank index");
    unmapped_strobe_a: assert property (tk && !REQ_POINTER[15] && !lin
        && REQ_POINTER > BANKED_LAST |=> !MEM.en) else $error("unmapped");
    cover property (lin);
    cover property (fl && !REQ_WRITE);
    cover property (fl && REQ_WRITE);
endmodule
bind indirect_memory_mapper imm_chk chk_u (.CLK, .ARST_N, .REQ_VALID,
    .REQ_WRITE, .REQ_POINTER, .REQ_BUSY, .MEM, .FLASH);

// >>> bench/imm_mem.sv
`timescale 1ns/1ps
module imm_mem
    import imm_pkg::*;
(
    // Strobe in, byte out.
    input wire logic CLK,
    input wire mem_req_s MEM,
    output logic [7:0] MEM_RDATA
);
    logic [7:0] ram [4096];
    // Byte store; an unselected read shows an inverted byte, not the last.
    assign MEM_RDATA = MEM.en ? ram[{MEM.bank, MEM.index}] : ~ram[0];
    always @(posedge CLK)
        if (MEM.en && MEM.we)
            ram[{MEM.bank, MEM.index}] <= MEM.wdata;
endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench
    import imm_pkg::*;
;
    // Stimulus, answers and tallies.
    logic CLK = 1'h0, ARST_N = 1'h0, REQ_VALID = 1'h0, REQ_WRITE = 1'h0;
    logic [15:0] REQ_POINTER = 16'h0000;
    logic [7:0] REQ_WDATA = 8'h00, RSP_RDATA, MEM_RDATA, rd;
    logic REQ_BUSY, RSP_VALID;
    logic [13:0] FLASH_RDATA;
    mem_req_s MEM;
    flash_req_s FLASH;
    int fail_count = 0, check_count = 0, n;
    // Mapper, data memory, and flash words that follow the address.
    indirect_memory_mapper dut_u (.CLK, .ARST_N, .REQ_VALID, .REQ_WRITE,
        .REQ_POINTER, .REQ_WDATA, .REQ_BUSY, .RSP_VALID, .RSP_RDATA, .MEM,
        .MEM_RDATA, .FLASH, .FLASH_RDATA);
    imm_mem mem_u (.CLK, .MEM, .MEM_RDATA);
    assign FLASH_RDATA = FLASH.en ? FLASH.addr[13:0] ^ 14'h2a5a : 14'h3fff;
    initial forever #5 CLK = ~CLK;
    task automatic chk(input string w, input logic [7:0] s, e);
        check_count++;
        if (s !== e) fail_count++;
        if (s !== e) $display("unexpected %s: expected %h seen %h", w, e, s);
    endtask
    // Request held over its take edge, then a bounded wait for the answer.
    task automatic acc(input logic w, logic [15:0] p, logic [7:0] d);
        @(negedge CLK);
        {REQ_VALID, REQ_WRITE, REQ_POINTER, REQ_WDATA} = {1'h1, w, p, d};
        @(negedge CLK);
        REQ_VALID = 1'h0;
        for (n = 0; RSP_VALID !== 1'h1 && n < 9; n++) @(negedge CLK);
        if (n == 9) fail_count++;
        rd = RSP_RDATA;
    endtask
    // Linear writes across a bank seam, read back through banked pointers.
    task automatic t_linear;
        acc(1'h1, 16'h204f, 8'h11);
        acc(1'h1, 16'h2050, 8'h22);
        acc(1'h0, 16'h00a0, 8'h00);
        chk("next bank first", rd, 8'h22);
        acc(1'h0, 16'h006f, 8'h00);
        chk("bank zero last", rd, 8'h11);
        acc(1'h1, 16'h0f6f, 8'h33);
        acc(1'h0, 16'h29af, 8'h00);
        chk("linear last", rd, 8'h33);
        $display("linear test done");
    endtask
    // Common RAM from two banks, data timing and an unmapped read.
    task automatic t_common;
        acc(1'h1, 16'h0075, 8'h44);
        acc(1'h0, 16'h0ff5, 8'h00);
        chk("common byte", rd, 8'h44);
        chk("data cycles", 8'(n), 8'h01);
        acc(1'h0, 16'h29b0, 8'h00);
        chk("unmapped byte", rd, 8'h00);
        $display("common test done");
    endtask
    // Flash window write, then a read of the same word.
    task automatic t_flash;
        acc(1'h1, 16'h8123, 8'hff);
        chk("flash write answer", rd, 8'h00);
        chk("flash write cycles", 8'(n), 8'h02);
        acc(1'h0, 16'h8123, 8'h00);
        chk("flash low byte", rd, 8'h79);
        chk("flash cycles", 8'(n), 8'h02);
        $display("flash test done");
    endtask
    // Reset for five cycles, then the scenarios.
    initial begin
        repeat (5) @(negedge CLK);
        ARST_N = 1'h1;
        t_linear();
        t_common();
        t_flash();
        close_out();
    end
    // Watchdog well past the expected run time.
    initial begin
        #5000 fail_count++;
        close_out();
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
endmodule
